// *** hdl/unf_uart_ctl1.sv ***
// Purpose: Baud generator readback and interrupt, receive interrupt gating, infrared routing and the
//          receive noise filter of a serial port, with its control registers on classic Wishbone.
// Assumes: One clock, synchronous active-high reset; the receiver and transmitter sit outside.
// Notes: Answers every access one cycle after the request, unmapped addresses read zero.
//
// Added by the designer: the Wishbone slave port.

`timescale 1ns/100ps
`default_nettype none

module unf_uart_ctl1 (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire unf_pkg::unf_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial pins and infrared codec.
	input wire logic rxd_i,
	output logic txd_o,
	output logic ir_enc_o,
	input wire logic ir_dec_i,
	// Receiver and transmitter core.
	input wire logic tx_bit_i,
	output logic rx_bit_o,
	input wire logic rx_data_ev_i,
	input wire logic rx_err_ev_i,
	output logic rx_enable_o,
	// Interrupt.
	output logic irq_o
);
	import unf_pkg::*;

	function automatic logic [10:0] unf_filt_max(input logic [2:0] code);
		unf_filt_max = UNF_FILT_FULL >> (UNF_FILT_TOP_CODE - code);
	endfunction

	logic ack_reg;
	logic [7:0] rd_reg;
	logic [7:0] ctl0_reg;
	logic [2:0] subsel_reg;
	logic [7:0] mp_reg;
	logic [7:0] nf_reg;
	logic [15:0] reload_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [2:0] stat_reg;
	logic [2:0] stat_next;
	logic [2:0] mask_reg;
	logic irq_reg;
	logic rxd_s1_reg;
	logic rxd_s2_reg;
	logic rxd_s3_reg;
	logic rxd_stable_reg;
	logic [10:0] cnt_reg;
	logic [10:0] cnt_next;
	logic filt_reg;
	logic filt_next;
	logic rx_bit_reg;
	logic txd_reg;
	logic ir_enc_reg;

	// Bus decode.
	wire req_go = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
	wire [13:0] idx = wb_req_i.adr[15:2];
	wire wr_go = req_go & wb_req_i.we & wb_req_i.sel[0];
	wire [7:0] wdat = wb_req_i.dat[7:0];
	wire hit_ctl0 = idx == UNF_IDX_CTL0;
	wire hit_ctl1 = idx == UNF_IDX_CTL1;
	wire hit_hi = idx == UNF_IDX_BAUD_HI;
	wire hit_lo = idx == UNF_IDX_BAUD_LO;
	wire hit_subsel = idx == UNF_IDX_SUBSEL;
	wire hit_stat = idx == UNF_IDX_IRQ_STAT;
	wire hit_mask = idx == UNF_IDX_IRQ_MASK;
	wire sub_multi = subsel_reg == UNF_SUB_MULTI;
	wire sub_filter = subsel_reg == UNF_SUB_FILTER;

	// Control fields.
	wire rx_en = ctl0_reg[UNF_CTL0_RX_EN_BIT];
	wire baud_ctl = mp_reg[UNF_MP_BAUD_CTL_BIT];
	wire rda_sup = mp_reg[UNF_MP_RDA_SUP_BIT];
	wire ir_en = mp_reg[UNF_MP_IR_EN_BIT];
	wire nf_en = nf_reg[UNF_NF_EN_BIT];
	wire [2:0] nf_width = nf_reg[UNF_NF_W_LSB +: 3];

	// Shared-address subregister view; unselected codes read zero and ignore writes.
	wire [7:0] sub_rd = sub_multi ? mp_reg : (sub_filter ? {nf_reg[7:4], 4'h0} : 8'h00);

	// Readback picks count or reload by the control bit alone in both receiver states.
	wire [15:0] baud_rd = baud_ctl ? count_reg : reload_reg;
	// Each byte is taken straight from the live value, so a carry between reads shows through.
	wire [7:0] rd_byte = hit_ctl0 ? ctl0_reg :
		hit_ctl1 ? sub_rd :
		hit_hi ? baud_rd[15:8] :
		hit_lo ? baud_rd[7:0] :
		hit_subsel ? {5'h00, subsel_reg} :
		hit_stat ? {5'h00, stat_reg} :
		hit_mask ? {5'h00, mask_reg} : 8'h00;

	// Baud generator: runs for the receiver, or on its own as a timer when the receiver is off.
	wire baud_run = rx_en | baud_ctl;
	wire baud_at_one = count_reg == 16'h0001;
	wire baud_hit = ~rx_en & baud_ctl & baud_at_one;
	always_comb begin
		if (!baud_run) begin
			count_next = reload_reg;
		end else if (count_reg <= 16'h0001) begin
			count_next = reload_reg;
		end else begin
			count_next = count_reg - 16'h0001;
		end
	end

	// Events; a set in the same cycle as its clear wins.
	wire [2:0] ev;
	assign ev[UNF_IRQ_BAUD_BIT] = baud_hit;
	assign ev[UNF_IRQ_RXDATA_BIT] = rx_data_ev_i & ~rda_sup;
	assign ev[UNF_IRQ_RXERR_BIT] = rx_err_ev_i;
	wire [2:0] stat_clr = (wr_go & hit_stat) ? wdat[2:0] : 3'h0;
	assign stat_next = (stat_reg & ~stat_clr) | ev;

	// Receive source and noise filter.
	wire raw_rx = ir_en ? ir_dec_i : rxd_stable_reg;
	wire [10:0] filt_max = unf_filt_max(nf_width);
	wire at_max = cnt_reg >= filt_max;
	wire at_zero = cnt_reg == 11'h000;
	assign cnt_next = raw_rx ? (at_max ? filt_max : cnt_reg + 11'h001) : (at_zero ? 11'h000 : cnt_reg - 11'h001);
	assign filt_next = at_max ? 1'b1 : (at_zero ? 1'b0 : filt_reg);

	// Bus slave.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rd_reg <= 8'h00;
		end else begin
			ack_reg <= req_go;
			rd_reg <= req_go ? rd_byte : 8'h00;
		end
	end

	// Software registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl0_reg <= UNF_CTL_RST;
			subsel_reg <= UNF_SUBSEL_RST;
			mp_reg <= UNF_CTL_RST;
			nf_reg <= UNF_CTL_RST;
			reload_reg <= UNF_RELOAD_RST;
			mask_reg <= UNF_IRQ_RST;
		end else if (wr_go) begin
			if (hit_ctl0) begin
				ctl0_reg <= wdat;
			end
			if (hit_subsel) begin
				subsel_reg <= wdat[2:0];
			end
			if (hit_ctl1 && sub_multi) begin
				mp_reg <= wdat;
			end
			if (hit_ctl1 && sub_filter) begin
				nf_reg <= {wdat[7:4], 4'h0};
			end
			if (hit_hi) begin
				reload_reg[15:8] <= wdat;
			end
			if (hit_lo) begin
				reload_reg[7:0] <= wdat;
			end
			if (hit_mask) begin
				mask_reg <= wdat[2:0];
			end
		end
	end

	// Baud counter and interrupt state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= UNF_RELOAD_RST;
			stat_reg <= UNF_IRQ_RST;
			irq_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			stat_reg <= stat_next;
			irq_reg <= |(stat_reg & mask_reg);
		end
	end

	// The pin passes three flops; a level is accepted only once the last two agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd_s1_reg <= 1'b1;
			rxd_s2_reg <= 1'b1;
			rxd_s3_reg <= 1'b1;
			rxd_stable_reg <= 1'b1;
		end else begin
			rxd_s1_reg <= rxd_i;
			rxd_s2_reg <= rxd_s1_reg;
			rxd_s3_reg <= rxd_s2_reg;
			if (rxd_s2_reg == rxd_s3_reg) begin
				rxd_stable_reg <= rxd_s3_reg;
			end
		end
	end

	// Filter and data routing. The counter runs even when bypassed so enabling it mid-line is glitch-free.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= UNF_FILT_CNT_RST;
			filt_reg <= 1'b1;
			rx_bit_reg <= 1'b1;
			txd_reg <= 1'b1;
			ir_enc_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			filt_reg <= filt_next;
			rx_bit_reg <= nf_en ? filt_reg : raw_rx;
			txd_reg <= ir_en ? 1'b1 : tx_bit_i;
			ir_enc_reg <= ir_en ? tx_bit_i : 1'b0;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = {24'h000000, rd_reg};
	assign rx_enable_o = rx_en;
	assign irq_o = irq_reg;
	assign rx_bit_o = rx_bit_reg;
	assign txd_o = txd_reg;
	assign ir_enc_o = ir_enc_reg;

	// Checks.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	wire rd_go = req_go & ~wb_req_i.we;

	property p_ack_next;
		req_go |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("Wishbone ack not given once after request.");

	property p_filter_view;
		rd_go && hit_ctl1 && sub_filter |=> wb_dat_o[7:0] == {$past(nf_reg[7:4]), 4'h0};
	endproperty
	a_filter_view: assert property (p_filter_view) else $error("Filter subregister read wrong.");

	property p_reserved_zero;
		nf_reg[3:0] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved filter bits not zero.");

	property p_baud_stopped;
		!rx_en && !baud_ctl ##1 !rx_en && !baud_ctl && $stable(reload_reg) |-> count_reg == reload_reg;
	endproperty
	a_baud_stopped: assert property (p_baud_stopped) else $error("Baud generator not held at reload.");

	property p_baud_event;
		!rx_en && baud_ctl && count_reg == 16'h0001 |=> stat_reg[UNF_IRQ_BAUD_BIT] && count_reg == $past(reload_reg);
	endproperty
	a_baud_event: assert property (p_baud_event) else $error("Baud event not raised at one.");

	property p_baud_count;
		baud_run && count_reg > 16'h0001 |=> count_reg == $past(count_reg) - 16'h0001;
	endproperty
	a_baud_count: assert property (p_baud_count) else $error("Baud generator did not count down.");

	property p_read_live;
		rd_go && hit_lo && baud_ctl |=> wb_dat_o[7:0] == $past(count_reg[7:0]);
	endproperty
	a_read_live: assert property (p_read_live) else $error("Low byte read not live count.");

	property p_data_irq;
		rx_data_ev_i && !rda_sup |=> stat_reg[UNF_IRQ_RXDATA_BIT];
	endproperty
	a_data_irq: assert property (p_data_irq) else $error("Received data did not set status.");

	property p_data_sup;
		rda_sup && !stat_reg[UNF_IRQ_RXDATA_BIT] |=> !stat_reg[UNF_IRQ_RXDATA_BIT];
	endproperty
	a_data_sup: assert property (p_data_sup) else $error("Suppressed data set status.");

	property p_err_irq;
		rx_err_ev_i |=> stat_reg[UNF_IRQ_RXERR_BIT] ##1 irq_o == $past(|(stat_reg & mask_reg));
	endproperty
	a_err_irq: assert property (p_err_irq) else $error("Receiver error did not set status.");

	property p_ir_route;
		ir_en |=> ir_enc_o == $past(tx_bit_i) && txd_o;
	endproperty
	a_ir_route: assert property (p_ir_route) else $error("Infrared transmit routing wrong.");

	property p_bypass;
		!nf_en |=> rx_bit_o == $past(raw_rx);
	endproperty
	a_bypass: assert property (p_bypass) else $error("Filter bypass wrong.");

	property p_width;
		(nf_width == 3'h0 |-> filt_max == 11'h00f) and (nf_width == 3'h7 |-> filt_max == 11'h7ff);
	endproperty
	a_width: assert property (p_width) else $error("Filter width ends wrong.");

	property p_width_mid;
		nf_width == 3'h3 |-> filt_max == 11'h07f;
	endproperty
	a_width_mid: assert property (p_width_mid) else $error("Width code 011 is not 7 bits.");

	property p_filt_switch;
		$changed(filt_reg) |-> $past(at_max) || $past(at_zero);
	endproperty
	a_filt_switch: assert property (p_filt_switch) else $error("Filter switched before saturation.");

	// With the receiver on the generator only paces the receiver, so it must never raise the timer event.
	property p_no_baud_ev_rx_on;
		rx_en && !stat_reg[UNF_IRQ_BAUD_BIT] |=> !stat_reg[UNF_IRQ_BAUD_BIT];
	endproperty
	a_no_baud_ev_rx_on: assert property (p_no_baud_ev_rx_on) else $error("Baud event raised with receiver on.");

	property p_stat_clear;
		wr_go && hit_stat && wdat[UNF_IRQ_RXERR_BIT] && !ev[UNF_IRQ_RXERR_BIT] |=> !stat_reg[UNF_IRQ_RXERR_BIT];
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("Write of one did not clear error status.");

	c_baud_event: cover property (baud_hit ##1 irq_o [*2]);
	c_filter_rise: cover property (nf_en && $rose(filt_reg));
	c_ir_rx: cover property (ir_en && nf_en && $fell(rx_bit_o));
	c_sub_write: cover property (wr_go && hit_ctl1 && sub_filter);
	c_live_rx_on: cover property (rd_go && hit_lo && baud_ctl && rx_en);

endmodule

`default_nettype wire

// *** hdl/unf_pkg.sv ***
// Purpose: Shared constants and types for the receive-path control block of the serial port.
// Assumes: Registers are eight bits wide, each in the low byte lane of one 32-bit Wishbone word.
// Notes: Register byte address is four times the register index.

`default_nettype none

package unf_pkg;

	// Register indices; byte address is index * 4.
	localparam logic [13:0] UNF_IDX_CTL0 = 14'h0f42;
	localparam logic [13:0] UNF_IDX_CTL1 = 14'h0f43;
	localparam logic [13:0] UNF_IDX_BAUD_HI = 14'h0f46;
	localparam logic [13:0] UNF_IDX_BAUD_LO = 14'h0f47;
	localparam logic [13:0] UNF_IDX_SUBSEL = 14'h0f50;
	localparam logic [13:0] UNF_IDX_IRQ_STAT = 14'h0f51;
	localparam logic [13:0] UNF_IDX_IRQ_MASK = 14'h0f52;

	// Subregister select codes behind the shared control address.
	localparam logic [2:0] UNF_SUB_MULTI = 3'h0;
	localparam logic [2:0] UNF_SUB_FILTER = 3'h1;

	// Field positions.
	localparam int unsigned UNF_CTL0_RX_EN_BIT = 0;
	localparam int unsigned UNF_MP_BAUD_CTL_BIT = 2;
	localparam int unsigned UNF_MP_RDA_SUP_BIT = 1;
	localparam int unsigned UNF_MP_IR_EN_BIT = 0;
	localparam int unsigned UNF_NF_EN_BIT = 7;
	localparam int unsigned UNF_NF_W_LSB = 4;
	localparam int unsigned UNF_IRQ_BAUD_BIT = 0;
	localparam int unsigned UNF_IRQ_RXDATA_BIT = 1;
	localparam int unsigned UNF_IRQ_RXERR_BIT = 2;

	// Reset values.
	localparam logic [7:0] UNF_CTL_RST = 8'h00;
	localparam logic [2:0] UNF_SUBSEL_RST = 3'h0;
	localparam logic [15:0] UNF_RELOAD_RST = 16'h00ff;
	localparam logic [2:0] UNF_IRQ_RST = 3'h0;
	localparam logic [10:0] UNF_FILT_CNT_RST = 11'h00f;
	localparam logic [10:0] UNF_FILT_FULL = 11'h7ff;
	localparam logic [2:0] UNF_FILT_TOP_CODE = 3'h7;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [15:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} unf_wb_req_t;

endpackage

`default_nettype wire

// *** sim/unf_line_model.sv ***
// Purpose: Serial line and infrared transceiver model on the receive side of the serial port.
// Assumes: The bench sets the line level and whether the transceiver path is in use.
// Notes: The decoder output toggles while unused, so a stale value cannot pass for data.
`timescale 1ns/100ps
`default_nettype none
module unf_line_model (
	// Clock.
	input wire logic clk_i,
	// Bench control.
	input wire logic level_i,
	input wire logic ir_i,
	// Line outputs.
	output logic rxd_o,
	output logic ir_dec_o
);
	logic tog_reg = 1'b0;
	always @(posedge clk_i) begin
		tog_reg <= ~tog_reg;
	end
	// The plain pin idles high while the transceiver carries the data.
	assign rxd_o = ir_i ? 1'b1 : level_i;
	assign ir_dec_o = ir_i ? level_i : tog_reg;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the receive-path control block.
// Assumes: Register access over classic Wishbone; one 40 MHz clock.
// Notes: Waits on the filter are sized from the counter widths with some slack.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import unf_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	unf_wb_req_t req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, txd_o, ir_enc_o, rx_bit_o, rx_enable_o, irq_o, rxd_i, ir_dec_i;
	logic tx_bit_i = 1'b1;
	logic rx_data_ev_i = 1'b0;
	logic rx_err_ev_i = 1'b0;
	logic level = 1'b1;
	logic ir = 1'b0;
	logic [7:0] q;
	int err_count = 0;
	int n_compared = 0;
	always #12.5 clk_i = ~clk_i;
	unf_uart_ctl1 uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rxd_i(rxd_i), .txd_o(txd_o), .ir_enc_o(ir_enc_o), .ir_dec_i(ir_dec_i), .tx_bit_i(tx_bit_i),
		.rx_bit_o(rx_bit_o), .rx_data_ev_i(rx_data_ev_i), .rx_err_ev_i(rx_err_ev_i),
		.rx_enable_o(rx_enable_o), .irq_o(irq_o));
	unf_line_model line (.clk_i(clk_i), .level_i(level), .ir_i(ir), .rxd_o(rxd_i), .ir_dec_o(ir_dec_i));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task waitc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		q = wb_dat_o[7:0];
		req <= '0;
		chk("ack", 1, wb_ack_o);
	endtask
	task rdc(input string nm, input logic [13:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		chk(nm, e, q);
	endtask
	task pulse(input logic err);
		@(posedge clk_i);
		rx_err_ev_i <= err;
		rx_data_ev_i <= ~err;
		@(posedge clk_i);
		rx_err_ev_i <= 1'b0;
		rx_data_ev_i <= 1'b0;
	endtask
	// Two low-byte reads three cycles apart; with a reload of five a running count cannot repeat.
	task live(input string nm);
		logic [7:0] a;
		wb(1'b0, UNF_IDX_BAUD_LO, 8'h00);
		a = q;
		wb(1'b0, UNF_IDX_BAUD_LO, 8'h00);
		chk(nm, 1, a >= 8'h01 && a <= 8'h05 && q >= 8'h01 && q <= 8'h05);
		chk(nm, 1, a != q);
	endtask
	task t_regs;
		rdc("baud high", UNF_IDX_BAUD_HI, 8'h00);
		rdc("baud low", UNF_IDX_BAUD_LO, 8'hff);
		wb(1, UNF_IDX_SUBSEL, UNF_SUB_FILTER);
		wb(1, UNF_IDX_CTL1, 8'hf0);
		rdc("filter ctl", UNF_IDX_CTL1, 8'hf0);
		wb(1, UNF_IDX_SUBSEL, UNF_SUB_MULTI);
		rdc("multi ctl", UNF_IDX_CTL1, 8'h00);
		wb(1, UNF_IDX_CTL1, 8'h58);
		rdc("multi ctl", UNF_IDX_CTL1, 8'h58);
		wb(1, UNF_IDX_SUBSEL, 8'h02);
		rdc("other sub", UNF_IDX_CTL1, 8'h00);
		wb(1, UNF_IDX_SUBSEL, UNF_SUB_FILTER);
		rdc("filter ctl", UNF_IDX_CTL1, 8'hf0);
		wb(1, UNF_IDX_CTL1, 8'h00);
		wb(1, UNF_IDX_SUBSEL, UNF_SUB_MULTI);
		wb(1, UNF_IDX_CTL1, 8'h00);
		rdc("unmapped", 14'h0f60, 8'h00);
	endtask
	task t_baud;
		wb(1, UNF_IDX_BAUD_HI, 8'h00);
		wb(1, UNF_IDX_BAUD_LO, 8'h05);
		rdc("reload", UNF_IDX_BAUD_LO, 8'h05);
		rdc("status", UNF_IDX_IRQ_STAT, 8'h00);
		wb(1, UNF_IDX_IRQ_MASK, 8'h01);
		wb(1, UNF_IDX_CTL1, 8'h04);
		waitc(10);
		live("count low");
		rdc("count high", UNF_IDX_BAUD_HI, 8'h00);
		rdc("status", UNF_IDX_IRQ_STAT, 8'h01);
		chk("irq", 1, irq_o);
		wb(1, UNF_IDX_CTL1, 8'h00);
		wb(1, UNF_IDX_IRQ_STAT, 8'h01);
		rdc("status", UNF_IDX_IRQ_STAT, 8'h00);
		waitc(2);
		chk("irq", 0, irq_o);
		wb(1, UNF_IDX_CTL0, 8'h01);
		chk("rx enable", 1, rx_enable_o);
		rdc("reload", UNF_IDX_BAUD_LO, 8'h05);
		wb(1, UNF_IDX_CTL1, 8'h04);
		live("count rx on");
		rdc("status rx on", UNF_IDX_IRQ_STAT, 8'h00);
		wb(1, UNF_IDX_CTL1, 8'h00);
		wb(1, UNF_IDX_CTL0, 8'h00);
	endtask
	task t_rxirq;
		wb(1, UNF_IDX_IRQ_MASK, 8'h06);
		pulse(0);
		waitc(3);
		chk("irq", 1, irq_o);
		rdc("status", UNF_IDX_IRQ_STAT, 8'h02);
		wb(1, UNF_IDX_IRQ_STAT, 8'h07);
		wb(1, UNF_IDX_CTL1, 8'h02);
		pulse(0);
		waitc(3);
		chk("irq", 0, irq_o);
		pulse(1);
		waitc(3);
		chk("irq", 1, irq_o);
		rdc("status", UNF_IDX_IRQ_STAT, 8'h04);
		wb(1, UNF_IDX_IRQ_STAT, 8'h04);
		wb(1, UNF_IDX_CTL1, 8'h00);
	endtask
	task t_route;
		for (int i = 0; i < 4; i++) begin
			wb(1, UNF_IDX_CTL1, {7'h00, i[1]});
			ir <= i[1];
			tx_bit_i <= i[0];
			level <= i[0];
			waitc(8);
			chk("txd", i[1] ? 1'b1 : i[0], txd_o);
			chk("ir enc", i[1] & i[0], ir_enc_o);
			chk("rx bit", i[0], rx_bit_o);
		end
	endtask
	task t_filt;
		wb(1, UNF_IDX_CTL1, 8'h00);
		ir <= 1'b0;
		waitc(20);
		wb(1, UNF_IDX_SUBSEL, UNF_SUB_FILTER);
		wb(1, UNF_IDX_CTL1, 8'h80);
		level <= 1'b0;
		waitc(8);
		chk("filtered", 1, rx_bit_o);
		waitc(20);
		chk("filtered", 0, rx_bit_o);
		wb(1, UNF_IDX_CTL1, 8'hb0);
		level <= 1'b1;
		waitc(100);
		chk("filtered", 0, rx_bit_o);
		waitc(40);
		chk("filtered", 1, rx_bit_o);
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		err_count++;
		results;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_baud;
		t_rxirq;
		t_route;
		t_filt;
		results;
	end
endmodule
`default_nettype wire
